// [verilog/csrpd_pkg.sv]
/*
 constants, types and helpers for the serial rgb pwm driver.
 assumes a 200 MHz system clock and a serial link clock from upstream.
*/
`default_nettype none
package csrpd_pkg;
    // ==========================================
    // frame layout
    localparam int unsigned CH_W      = 8;
    localparam int unsigned FRAME_W   = 24;
    localparam int unsigned CNT_W     = 5;
    localparam int unsigned RED_LO    = 16;
    localparam int unsigned GRN_LO    = 8;
    localparam int unsigned BLU_LO    = 0;
    localparam logic [4:0]  LAST_BIT  = 5'h17;
    localparam logic [23:0] FRAME_RST = 24'h000000;
    localparam int unsigned BUF_DEPTH = 2;
    // ==========================================
    // pwm
    localparam logic [7:0]  PWM_LAST  = 8'hFF;
    localparam logic [7:0]  LVL_RST   = 8'h00;
    // ==========================================
    // timing
    localparam int unsigned MCLK_PS   = 5000;
    localparam int unsigned T_LOW_NS  = 500000;
    localparam int unsigned LOW_CYC   =
        (T_LOW_NS * 1000 + MCLK_PS - 1) / MCLK_PS;
    localparam int unsigned LOW_W     = 17;
    // ==========================================
    // receiver state
    typedef enum logic {RX_COLLECT, RX_RELAY} csrpd_rx_e;

    function automatic logic [7:0] csrpd_chan(
        input logic [23:0] f,
        input int unsigned lo);
        return f[lo +: CH_W];
    endfunction
endpackage
`default_nettype wire

// [verilog/csrpd_link_rx.sv]
/*
 link side capture, clocked by the serial clock itself.
 assumes the core syncs o_tog and o_bit, and that the serial
 clock stays low while reset is released.
*/
`timescale 1ns/1ps
`default_nettype none
module csrpd_link_rx (
    input  wire logic i_serial_clock_in,
    input  wire logic i_resetn,
    input  wire logic i_serial_data_in,
    output logic      o_tog,
    output logic      o_bit
);
    // ==========================================
    // one toggle per rising edge, bit held till next edge
    // async clear: the serial clock is idle around reset, so a
    // release synced to it would leave the toggle unknown or
    // swallow the first edges of the next frame
    always_ff @(posedge i_serial_clock_in or negedge i_resetn) begin
        if (!i_resetn) begin
            o_tog <= 1'b0;
            o_bit <= 1'b0;
        end else begin
            o_tog <= ~o_tog;
            o_bit <= i_serial_data_in;
        end
    end
endmodule
`default_nettype wire

// [verilog/csrpd_buf2.sv]
/*
 two-entry valid/ready buffer.
 assumes both sides on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module csrpd_buf2 #(
    parameter int unsigned W = 24
) (
    input  wire logic         i_mclk,
    input  wire logic         i_resetn,
    input  wire logic         i_in_valid,
    output logic              o_in_ready,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_out_valid,
    input  wire logic         i_out_ready,
    output logic [W-1:0]      o_out_data
);
    logic [W-1:0] mem_q [2];
    logic         wr_q;
    logic         rd_q;
    logic [1:0]   cnt_q;
    logic         push;
    logic         pop;

    assign o_in_ready  = (cnt_q != 2'h2);
    assign o_out_valid = (cnt_q != 2'h0);
    assign o_out_data  = mem_q[rd_q];
    assign push = i_in_valid && o_in_ready;
    assign pop  = o_out_valid && i_out_ready;

    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem_q[wr_q] <= i_in_data;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            wr_q  <= wr_q ^ push;
            rd_q  <= rd_q ^ pop;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule
`default_nettype wire

// [verilog/csrpd_driver.sv]
/*
 serial rgb pwm driver core: frame receive, relay, pwm.
 assumes i_serial_clock_in also clocks the link capture and
 that serial and polarity pins are asynchronous to i_mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module csrpd_driver
    import csrpd_pkg::*;
#(
    parameter int unsigned LONG_LOW_CYCLES = csrpd_pkg::LOW_CYC
) (
    input  wire logic i_mclk,
    input  wire logic i_resetn,
    input  wire logic i_serial_clock_in,
    input  wire logic i_serial_data_in,
    input  wire logic i_polarity_select,
    output logic      o_serial_data_out,
    output logic      o_buffered_clock_out,
    output logic      o_red_drive_out,
    output logic      o_green_drive_out,
    output logic      o_blue_drive_out
);
    import csrpd_pkg::*;

    // ==========================================
    // declarations
    logic              ck_s1_q;
    logic              ck_s2_q;
    logic              dat_s1_q;
    logic              dat_s2_q;
    logic              pol_s1_q;
    logic              pol_s2_q;
    logic              tog_s1_q;
    logic              tog_s2_q;
    logic              tog_s3_q;
    logic              tog_s4_q;
    logic              bit_s1_q;
    logic              bit_s2_q;
    logic              link_tog;
    logic              link_bit;
    logic              bit_ev;
    logic [LOW_W-1:0]  low_cnt_q;
    logic              low_fire;
    csrpd_rx_e         state_q;
    logic [CNT_W-1:0]  bit_cnt_q;
    logic [23:0]       shift_q;
    logic              pend_q;
    logic [23:0]       frame_q;
    logic              buf_in_ready;
    logic              buf_out_valid;
    logic              buf_out_ready;
    logic [23:0]       buf_out_data;
    logic [7:0]        pwm_cnt_q;
    logic [7:0]        red_lvl_q;
    logic [7:0]        grn_lvl_q;
    logic [7:0]        blu_lvl_q;
    logic              pwm_end;

    // ==========================================
    // link capture on the serial clock
    csrpd_link_rx u_rx (
        .i_serial_clock_in (i_serial_clock_in),
        .i_resetn          (i_resetn),
        .i_serial_data_in  (i_serial_data_in),
        .o_tog             (link_tog),
        .o_bit             (link_bit)
    );

    // ==========================================
    // pin synchronisers
    always_ff @(posedge i_mclk) begin
        ck_s1_q <= i_serial_clock_in;
        ck_s2_q <= ck_s1_q;
    end

    always_ff @(posedge i_mclk) begin
        dat_s1_q <= i_serial_data_in;
        dat_s2_q <= dat_s1_q;
    end

    // floating polarity pin is pulled high outside
    always_ff @(posedge i_mclk) begin
        pol_s1_q <= i_polarity_select;
        pol_s2_q <= pol_s1_q;
    end

    // ==========================================
    // bit event crossing
    // toggle gets two extra stages so the bit path
    // has settled before it is read
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            tog_s3_q <= 1'b0;
            tog_s4_q <= 1'b0;
        end else begin
            tog_s1_q <= link_tog;
            tog_s2_q <= tog_s1_q;
            tog_s3_q <= tog_s2_q;
            tog_s4_q <= tog_s3_q;
        end
    end

    always_ff @(posedge i_mclk) begin
        bit_s1_q <= link_bit;
        bit_s2_q <= bit_s1_q;
    end

    assign bit_ev = tog_s3_q ^ tog_s4_q;

    // ==========================================
    // long low detection
    // counter saturates so the reset fires once per idle
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            low_cnt_q <= '0;
        end else if (ck_s2_q) begin
            low_cnt_q <= '0;
        end else if (low_cnt_q != LOW_W'(LONG_LOW_CYCLES)) begin
            low_cnt_q <= low_cnt_q + 1'b1;
        end
    end

    assign low_fire = !ck_s2_q
        && (low_cnt_q == LOW_W'(LONG_LOW_CYCLES - 1));

    // ==========================================
    // receive state
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            state_q <= RX_COLLECT;
        end else if (low_fire) begin
            state_q <= RX_COLLECT;
        end else begin
            case (state_q)
                RX_COLLECT: begin
                    if (bit_ev && bit_cnt_q == LAST_BIT) begin
                        state_q <= RX_RELAY;
                    end
                end
                RX_RELAY: begin
                    state_q <= RX_RELAY;
                end
                default: begin
                    state_q <= RX_COLLECT;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            bit_cnt_q <= '0;
        end else if (low_fire) begin
            bit_cnt_q <= '0;
        end else if (bit_ev && state_q == RX_COLLECT) begin
            bit_cnt_q <= bit_cnt_q + 1'b1;
        end
    end

    // msb enters first and ends up at the top
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            shift_q <= FRAME_RST;
        end else if (bit_ev && state_q == RX_COLLECT) begin
            shift_q <= {shift_q[22:0], bit_s2_q};
        end
    end

    // ==========================================
    // frame latch, held while the buffer is full
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            pend_q  <= 1'b0;
            frame_q <= FRAME_RST;
        end else if (low_fire && bit_cnt_q != '0) begin
            pend_q  <= 1'b1;
            frame_q <= shift_q;
        end else if (pend_q && buf_in_ready) begin
            pend_q  <= 1'b0;
        end
    end

    csrpd_buf2 #(
        .W (FRAME_W)
    ) u_buf (
        .i_mclk      (i_mclk),
        .i_resetn    (i_resetn),
        .i_in_valid  (pend_q),
        .o_in_ready  (buf_in_ready),
        .i_in_data   (frame_q),
        .o_out_valid (buf_out_valid),
        .i_out_ready (buf_out_ready),
        .o_out_data  (buf_out_data)
    );

    // ==========================================
    // relay outputs
    // both paths share the same flop depth, so clock
    // and data leave aligned
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_buffered_clock_out <= 1'b0;
        end else begin
            o_buffered_clock_out <= ck_s2_q;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_serial_data_out <= 1'b0;
        end else if (state_q == RX_RELAY) begin
            o_serial_data_out <= dat_s2_q;
        end else begin
            o_serial_data_out <= 1'b0;
        end
    end

    // ==========================================
    // pwm timebase, 256 steps
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            pwm_cnt_q <= '0;
        end else begin
            pwm_cnt_q <= pwm_cnt_q + 1'b1;
        end
    end

    assign pwm_end = (pwm_cnt_q == PWM_LAST);
    assign buf_out_ready = pwm_end;

    // levels only move at the cycle boundary
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            red_lvl_q <= LVL_RST;
            grn_lvl_q <= LVL_RST;
            blu_lvl_q <= LVL_RST;
        end else if (pwm_end && buf_out_valid) begin
            red_lvl_q <= csrpd_chan(buf_out_data, RED_LO);
            grn_lvl_q <= csrpd_chan(buf_out_data, GRN_LO);
            blu_lvl_q <= csrpd_chan(buf_out_data, BLU_LO);
        end
    end

    // strict compare: 0 never on, ff on 255 of 256
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_red_drive_out   <= 1'b0;
            o_green_drive_out <= 1'b0;
            o_blue_drive_out  <= 1'b0;
        end else begin
            o_red_drive_out   <= (pwm_cnt_q < red_lvl_q) ^ !pol_s2_q;
            o_green_drive_out <= (pwm_cnt_q < grn_lvl_q) ^ !pol_s2_q;
            o_blue_drive_out  <= (pwm_cnt_q < blu_lvl_q) ^ !pol_s2_q;
        end
    end

    // ==========================================
    // assertions
    a_long_low_reset: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        low_fire |=> state_q == RX_COLLECT && bit_cnt_q == '0)
        else $error("long low did not reset receiver");

    a_latch_frame: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        (low_fire && bit_cnt_q != '0) |=> pend_q && frame_q == $past(shift_q))
        else $error("frame not latched on long low");

    a_relay_after_24: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        (bit_ev && state_q == RX_COLLECT && bit_cnt_q == LAST_BIT && !low_fire)
        |=> state_q == RX_RELAY)
        else $error("relay not entered after last bit");

    a_relay_forward: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        state_q == RX_RELAY |=> o_serial_data_out == $past(dat_s2_q))
        else $error("relay data not forwarded");

    a_frame_bound: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        state_q == RX_COLLECT |-> bit_cnt_q <= LAST_BIT)
        else $error("bit count passed frame length");

    a_msb_first: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        (bit_ev && state_q == RX_COLLECT) |=>
        shift_q[23:1] == $past(shift_q[22:0]) && shift_q[0] == $past(bit_s2_q))
        else $error("shift order wrong");

    a_zero_duty: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        (red_lvl_q == 8'h00 && pol_s2_q) |=> !o_red_drive_out)
        else $error("zero level drove output");

    a_full_duty_gap: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        (pwm_end && grn_lvl_q == 8'hFF && pol_s2_q) |=> !o_green_drive_out)
        else $error("full level not off in last step");

    a_reload_edge: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        (blu_lvl_q != $past(blu_lvl_q)) |-> $past(pwm_cnt_q) == PWM_LAST)
        else $error("level changed mid cycle");

    a_polarity_inv: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        (!pol_s2_q && grn_lvl_q == 8'h00) |=> o_green_drive_out)
        else $error("inverted polarity not applied");

    a_collect_quiet: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        state_q == RX_COLLECT |=> !o_serial_data_out)
        else $error("data relayed outside relay mode");

    a_clock_copy: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        $rose(ck_s2_q) |=> o_buffered_clock_out)
        else $error("clock output not following input");

    a_relay_hold: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        (state_q == RX_RELAY && !low_fire) |=> state_q == RX_RELAY && $stable(shift_q))
        else $error("relay left or shift changed");

    c_relay_entered: cover property (
        @(posedge i_mclk) disable iff (!i_resetn)
        $rose(state_q == RX_RELAY));

    c_frame_pushed: cover property (
        @(posedge i_mclk) disable iff (!i_resetn)
        pend_q && buf_in_ready);

    c_buffer_stall: cover property (
        @(posedge i_mclk) disable iff (!i_resetn)
        pend_q && !buf_in_ready);

    c_level_reload: cover property (
        @(posedge i_mclk) disable iff (!i_resetn)
        pwm_end && buf_out_valid);

    c_inverted_run: cover property (
        @(posedge i_mclk) disable iff (!i_resetn)
        !pol_s2_q && pwm_end);
endmodule
`default_nettype wire

// [verification/csrpd_upstream.sv]
/*
 upstream controller model: drives serial clock and data into the driver.
 assumes the bench calls its tasks hierarchically, one frame at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module csrpd_upstream (
    output logic o_sclk,
    output logic o_sdat
);
    logic bclk;

    initial begin
        bclk   = 1'b0;
        o_sclk = 1'b0;
        o_sdat = 1'b0;
    end

    // 6 ns base; serial clock moves only inside frames
    always #3 bclk = ~bclk;

    // ==========================================
    // bit and frame tasks
    // 9 base periods a bit keeps the serial period above 40 ns
    task automatic send_bit(input logic b);
        @(posedge bclk);
        o_sdat <= b;
        repeat (4) @(posedge bclk);
        o_sclk <= 1'b1;
        repeat (4) @(posedge bclk);
        o_sclk <= 1'b0;
    endtask

    task automatic send_frame(input logic [23:0] f);
        for (int i = 23; i >= 0; i--) begin
            send_bit(f[i]);
        end
    endtask

    task automatic send_tail(input logic [7:0] t);
        for (int i = 7; i >= 0; i--) begin
            send_bit(t[i]);
        end
    endtask

    // released data shows the inverse; clock held low past the limit
    task automatic end_frame();
        @(posedge bclk);
        o_sdat <= ~o_sdat;
        repeat (260) @(posedge bclk);
    endtask
endmodule
`default_nettype wire

// [verification/csrpd_driver_tb.sv]
/*
 self-checking bench for the serial rgb pwm driver.
 assumes LONG_LOW_CYCLES of 200 and the upstream model in its own file.
*/
`timescale 1ns/1ps
`default_nettype none
module csrpd_driver_tb;
    logic        i_mclk;
    logic        i_resetn;
    logic        i_polarity_select;
    logic        sclk;
    logic        sdat;
    logic        o_sdo;
    logic        o_cko;
    logic        o_red;
    logic        o_grn;
    logic        o_blu;
    int          err_total;
    int          num_checks;
    logic [31:0] cap;
    logic [31:0] ncap;
    logic        cap_en;

    csrpd_upstream up (
        .o_sclk (sclk),
        .o_sdat (sdat)
    );

    csrpd_driver #(.LONG_LOW_CYCLES(200)) dut (
        .i_mclk               (i_mclk),
        .i_resetn             (i_resetn),
        .i_serial_clock_in    (sclk),
        .i_serial_data_in     (sdat),
        .i_polarity_select    (i_polarity_select),
        .o_serial_data_out    (o_sdo),
        .o_buffered_clock_out (o_cko),
        .o_red_drive_out      (o_red),
        .o_green_drive_out    (o_grn),
        .o_blue_drive_out     (o_blu)
    );

    always #2.5 i_mclk = ~i_mclk;

    // data and clock leave through the same delay, so sample just past the edge
    always @(posedge o_cko) begin
        if (cap_en) begin
            #1;
            cap = {cap[30:0], o_sdo};
            ncap = ncap + 32'h1;
        end
    end

    // ==========================================
    // checking helpers
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic duty(input logic [7:0] r, input logic [7:0] g, input logic [7:0] b, input logic p);
        logic [31:0] nr;
        logic [31:0] ng;
        logic [31:0] nb;
        nr = 32'h0;
        ng = 32'h0;
        nb = 32'h0;
        repeat (256) begin
            @(negedge i_mclk);
            nr = nr + {31'h0, o_red};
            ng = ng + {31'h0, o_grn};
            nb = nb + {31'h0, o_blu};
        end
        chk("red duty", p ? {24'h0, r} : 32'h100 - {24'h0, r}, nr);
        chk("green duty", p ? {24'h0, g} : 32'h100 - {24'h0, g}, ng);
        chk("blue duty", p ? {24'h0, b} : 32'h100 - {24'h0, b}, nb);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ==========================================
    // scenarios
    task automatic s_frame_duty();
        up.send_frame(24'h8000FF);
        up.end_frame();
        repeat (600) @(posedge i_mclk);
        duty(8'h80, 8'h00, 8'hFF, 1'b1);
    endtask

    task automatic s_polarity();
        @(posedge i_mclk);
        i_polarity_select <= 1'b0;
        repeat (10) @(posedge i_mclk);
        duty(8'h80, 8'h00, 8'hFF, 1'b0);
        @(posedge i_mclk);
        i_polarity_select <= 1'b1;
        repeat (10) @(posedge i_mclk);
    endtask

    task automatic s_relay();
        cap = 32'h0;
        ncap = 32'h0;
        cap_en = 1'b1;
        up.send_frame(24'h123456);
        up.send_tail(8'hA5);
        up.end_frame();
        cap_en = 1'b0;
        chk("relay edges", 32'h20, ncap);
        chk("relay data", 32'h000000A5, cap);
        repeat (600) @(posedge i_mclk);
        duty(8'h12, 8'h34, 8'h56, 1'b1);
    endtask

    // a load in mid-period would show a high run of neither length
    task automatic s_reload();
        logic [31:0] run;
        logic        seen;
        run = 32'h0;
        seen = 1'b0;
        fork
            begin
                up.send_frame(24'h40FF00);
                up.end_frame();
            end
            repeat (1800) begin
                @(negedge i_mclk);
                if (o_red) begin
                    run = run + 32'h1;
                end else begin
                    if (run != 32'h0 && seen) begin
                        chk("red run", (run === 32'h40) ? 32'h40 : 32'h12, run);
                    end
                    if (run != 32'h0) begin
                        seen = 1'b1;
                    end
                    run = 32'h0;
                end
            end
        join
        duty(8'h40, 8'hFF, 8'h00, 1'b1);
    endtask

    // ==========================================
    // main sequence and watchdog
    initial begin
        i_mclk = 1'b0;
        i_resetn = 1'b0;
        i_polarity_select = 1'b1;
        err_total = 0;
        num_checks = 0;
        cap = 32'h0;
        ncap = 32'h0;
        cap_en = 1'b0;
        repeat (2) @(posedge i_mclk);
        i_resetn <= 1'b1;
        repeat (4) @(posedge i_mclk);
        s_frame_duty();
        s_polarity();
        s_relay();
        s_reload();
        tally_and_finish();
    end

    initial begin
        #100us;
        err_total++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
